// ### src/aclia_top.sv
// Purpose: per-port rule-table access through indirect byte registers
// Assumes: host requests synchronous to i_ref_clk, one per cycle at most
// Notes:   rule layout and packet matching live elsewhere
//
// Function
// - select byte: table code in bits 7:5, port index in bits 3:0
// - offset 0x10 holds mask bits 13:8 low; top two bits read zero
// - offset 0x11 holds mask bits 7:0, read/write, reset zero
// - each rule entry is fourteen bytes, mask has fourteen bits
// - mask bit one moves its byte in the next transfer, zero skips it
// - mask bit 0 selects byte 0x0d, up to bit 13 selecting byte 0x00
// - offset 0x12 holds direction, entry index and done flags; bit 7 zero
// - bit 6 write-done: zero while writing, one when done and after reset
// - bit 5 read-done: zero while reading, one when done and after reset
// - bit 4 direction: one writes buffer to table, zero reads; reset zero
// - bits 3:0 select entry 0 to 15, reset zero
// - offset 0x13 bit 0 forces ring frame miss with single-entry matching
// - write copies only mask-selected holding bytes into the entry
`timescale 1ns/100ps
`default_nettype none
`include "aclia_regs.svh"

module aclia_top (
    // clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_resetn,
    // indirect host access
    input  wire aclia_pkg::aclia_req_t i_req,
    output var  logic [7:0]        o_rdata,
    output var  logic              o_rd_valid,
    // matching control and transfer busy per port
    output var  logic [4:0]        o_redundancy_miss_force,
    output var  logic [4:0]        o_busy
);

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    // returns {hit, array index}
    function automatic logic [3:0] port_of(input logic [7:0] sel);
        logic [3:0] p;
        logic       hit;
        p   = sel[`ACLIA_SEL_PORT_MSB:0];
        hit = (sel[`ACLIA_SEL_CODE_MSB:`ACLIA_SEL_CODE_LSB] == `ACLIA_TABLE_CODE)
            && (p >= `ACLIA_PORT_FIRST)
            && (p <= `ACLIA_PORT_LAST);
        p   = p - 4'h1;
        return {hit, p[2:0]};
    endfunction : port_of

    // mask bit that selects a given entry byte
    function automatic logic byte_on(input logic [13:0] mask,
                                     input logic [3:0]  b);
        logic [3:0] k;
        k = `ACLIA_LAST_BYTE - b;
        return mask[k];
    endfunction : byte_on

    // ----------------------------------------
    // state
    // ----------------------------------------
    aclia_pkg::aclia_st_t r;
    aclia_pkg::aclia_st_t next_r;

    logic [3:0]  rq_port;
    logic        rq_hit;
    logic [2:0]  rq_idx;
    logic [2:0]  mv_p;
    logic [3:0]  mv_e;
    logic [3:0]  mv_b;

    assign rq_port = port_of(i_req.sel);
    assign rq_hit  = rq_port[3];
    assign rq_idx  = rq_port[2:0];
    assign mv_p    = r.port;
    assign mv_e    = r.ports[r.port].entry;
    assign mv_b    = r.idx;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_r          = r;
        next_r.rd_valid = 1'b0;

        // host read answer, one cycle later
        if (i_req.rd) begin
            next_r.rd_valid = 1'b1;
            next_r.rdata    = 8'h00;
            if (rq_hit) begin
                if (i_req.offset <= `ACLIA_OFF_HOLD_LAST) begin
                    next_r.rdata = r.ports[rq_idx].hold[i_req.offset[3:0]];
                end else begin
                    case (i_req.offset)
                        `ACLIA_OFF_MASK_HI: begin
                            next_r.rdata = {2'h0,
                                r.ports[rq_idx].byte_select_mask[13:8]};
                        end
                        `ACLIA_OFF_MASK_LO: begin
                            next_r.rdata =
                                r.ports[rq_idx].byte_select_mask[7:0];
                        end
                        `ACLIA_OFF_CTRL: begin
                            next_r.rdata = {1'b0,
                                r.ports[rq_idx].wr_done,
                                r.ports[rq_idx].rd_done,
                                r.ports[rq_idx].dir,
                                r.ports[rq_idx].entry};
                        end
                        `ACLIA_OFF_FILTER: begin
                            next_r.rdata = {7'h00,
                                r.ports[rq_idx].redundancy_miss_force};
                        end
                        default: begin
                            next_r.rdata = 8'h00;
                        end
                    endcase
                end
            end
        end

        // host write
        if (i_req.wr && rq_hit) begin
            if (i_req.offset <= `ACLIA_OFF_HOLD_LAST) begin
                next_r.ports[rq_idx].hold[i_req.offset[3:0]] = i_req.wdata;
            end else begin
                case (i_req.offset)
                    `ACLIA_OFF_MASK_HI: begin
                        next_r.ports[rq_idx].byte_select_mask[13:8] =
                            i_req.wdata[`ACLIA_MASK_HI_W-1:0];
                    end
                    `ACLIA_OFF_MASK_LO: begin
                        next_r.ports[rq_idx].byte_select_mask[7:0] =
                            i_req.wdata;
                    end
                    `ACLIA_OFF_CTRL: begin
                        // refused while a transfer runs
                        if (r.fsm == aclia_pkg::ACLIA_IDLE) begin
                            next_r.ports[rq_idx].dir =
                                i_req.wdata[`ACLIA_CTRL_DIR];
                            next_r.ports[rq_idx].entry =
                                i_req.wdata[3:0];
                            if (i_req.wdata[`ACLIA_CTRL_DIR]) begin
                                next_r.ports[rq_idx].wr_done = 1'b0;
                            end else begin
                                next_r.ports[rq_idx].rd_done = 1'b0;
                            end
                            next_r.port = rq_idx;
                            next_r.idx  = 4'h0;
                            next_r.fsm  = aclia_pkg::ACLIA_MOVE;
                        end
                    end
                    `ACLIA_OFF_FILTER: begin
                        next_r.ports[rq_idx].redundancy_miss_force =
                            i_req.wdata[`ACLIA_FILTER_MISS];
                    end
                    default: begin
                        next_r.fsm = r.fsm;
                    end
                endcase
            end
        end

        // transfer engine, one entry byte per cycle
        case (r.fsm)
            aclia_pkg::ACLIA_IDLE: begin
                next_r.busy = 5'h00;
            end
            aclia_pkg::ACLIA_MOVE: begin
                next_r.busy        = 5'h00;
                next_r.busy[mv_p]  = 1'b1;
                if (byte_on(r.ports[mv_p].byte_select_mask, mv_b)) begin
                    if (r.ports[mv_p].dir) begin
                        next_r.rules[mv_p][mv_e][mv_b] =
                            r.ports[mv_p].hold[mv_b];
                    end else begin
                        next_r.ports[mv_p].hold[mv_b] =
                            r.rules[mv_p][mv_e][mv_b];
                    end
                end
                next_r.idx = r.idx + 4'h1;
                if (r.idx == `ACLIA_LAST_BYTE) begin
                    next_r.idx = 4'h0;
                    next_r.fsm = aclia_pkg::ACLIA_IDLE;
                    if (r.ports[mv_p].dir) begin
                        next_r.ports[mv_p].wr_done = 1'b1;
                    end else begin
                        next_r.ports[mv_p].rd_done = 1'b1;
                    end
                end
            end
            default: begin
                next_r.fsm = aclia_pkg::ACLIA_IDLE;
            end
        endcase

        // filter flags shown on pins
        for (int p = 0; p < `ACLIA_NUM_PORTS; p++) begin
            next_r.miss_force[p] = next_r.ports[p].redundancy_miss_force;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            r.fsm        <= aclia_pkg::ACLIA_IDLE;
            r.port       <= 3'h0;
            r.idx        <= 4'h0;
            r.rules      <= '0;
            r.rdata      <= 8'h00;
            r.rd_valid   <= 1'b0;
            r.miss_force <= 5'h00;
            r.busy       <= 5'h00;
            for (int p = 0; p < `ACLIA_NUM_PORTS; p++) begin
                r.ports[p].byte_select_mask      <= `ACLIA_RST_MASK;
                r.ports[p].wr_done               <= `ACLIA_RST_DONE;
                r.ports[p].rd_done               <= `ACLIA_RST_DONE;
                r.ports[p].dir                   <= `ACLIA_RST_DIR;
                r.ports[p].entry                 <= `ACLIA_RST_ENTRY;
                r.ports[p].redundancy_miss_force <= `ACLIA_RST_MISS;
                r.ports[p].hold                  <= '0;
            end
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_rdata    = r.rdata;
    assign o_rd_valid = r.rd_valid;

    for (genvar g = 0; g < `ACLIA_NUM_PORTS; g++) begin : g_port_out
        assign o_redundancy_miss_force[g] = r.miss_force[g];
        assign o_busy[g]                  = r.busy[g];
    end

endmodule : aclia_top

`default_nettype wire

// ### src/aclia_regs.svh
// Purpose: offsets, fields, resets and counts of the rule-table access block
// Assumes: byte-wide indirect access, one clock
// Notes:   definitions only
`ifndef ACLIA_REGS_SVH
`define ACLIA_REGS_SVH

// ----------------------------------------
// indirect select byte
// ----------------------------------------
`define ACLIA_TABLE_CODE      3'h2
`define ACLIA_SEL_CODE_MSB    7
`define ACLIA_SEL_CODE_LSB    5
`define ACLIA_SEL_PORT_MSB    3
`define ACLIA_PORT_FIRST      4'h1
`define ACLIA_PORT_LAST       4'h5
`define ACLIA_NUM_PORTS       5

// ----------------------------------------
// offsets
// ----------------------------------------
`define ACLIA_OFF_HOLD_LAST   8'h0d
`define ACLIA_OFF_MASK_HI     8'h10
`define ACLIA_OFF_MASK_LO     8'h11
`define ACLIA_OFF_CTRL        8'h12
`define ACLIA_OFF_FILTER      8'h13

// ----------------------------------------
// fields
// ----------------------------------------
`define ACLIA_MASK_HI_W       6
`define ACLIA_CTRL_WDONE      6
`define ACLIA_CTRL_RDONE      5
`define ACLIA_CTRL_DIR        4
`define ACLIA_FILTER_MISS     0

// ----------------------------------------
// sizes and reset values
// ----------------------------------------
`define ACLIA_ENTRY_BYTES     14
`define ACLIA_NUM_ENTRIES     16
`define ACLIA_LAST_BYTE       4'hd
`define ACLIA_RST_MASK        14'h0000
`define ACLIA_RST_DONE        1'b1
`define ACLIA_RST_DIR         1'b0
`define ACLIA_RST_ENTRY       4'h0
`define ACLIA_RST_MISS        1'b0

`endif

// ### src/aclia_pkg.sv
// Purpose: types of the rule-table access block
// Assumes: constants come from aclia_regs.svh
// Notes:   all state is one packed struct
`include "aclia_regs.svh"

package aclia_pkg;

    // ----------------------------------------
    // host request carrier
    // ----------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] sel;
        logic [7:0] offset;
        logic [7:0] wdata;
    } aclia_req_t;

    // ----------------------------------------
    // per-port registers and holding buffer
    // ----------------------------------------
    typedef struct packed {
        logic [13:0]      byte_select_mask;
        logic             wr_done;
        logic             rd_done;
        logic             dir;
        logic [3:0]       entry;
        logic             redundancy_miss_force;
        logic [13:0][7:0] hold;
    } aclia_port_t;

    typedef enum logic [1:0] {
        ACLIA_IDLE = 2'b01,
        ACLIA_MOVE = 2'b10
    } aclia_fsm_t;

    typedef logic [15:0][13:0][7:0] aclia_rules_t;

    // ----------------------------------------
    // whole module state
    // ----------------------------------------
    typedef struct packed {
        aclia_fsm_t                fsm;
        logic [2:0]                port;
        logic [3:0]                idx;
        aclia_port_t  [4:0]        ports;
        aclia_rules_t [4:0]        rules;
        logic [7:0]                rdata;
        logic                      rd_valid;
        logic [4:0]                miss_force;
        logic [4:0]                busy;
    } aclia_st_t;

endpackage : aclia_pkg

// ### test/aclia_top_sva.sv
// Purpose: port checks of the rule-table access block
// Assumes: one clock, async active-low reset
// Notes:   bound to aclia_top
`timescale 1ns/100ps
`default_nettype none
`include "aclia_regs.svh"

module aclia_top_sva (
    // clock and reset
    input wire logic                  i_ref_clk,
    input wire logic                  i_resetn,
    // watched ports
    input wire aclia_pkg::aclia_req_t i_req,
    input wire logic [7:0]            o_rdata,
    input wire logic                  o_rd_valid,
    input wire logic [4:0]            o_redundancy_miss_force,
    input wire logic [4:0]            o_busy
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    logic ctrl_any;
    logic ctrl_p1;
    logic ctrl_q;
    assign ctrl_any = i_req.wr && i_req.sel[7:5] == `ACLIA_TABLE_CODE
                      && i_req.offset == `ACLIA_OFF_CTRL;
    assign ctrl_p1  = ctrl_any && i_req.sel[3:0] == 4'h1;
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_any;
        end
    end
    sequence s_start1;
        ctrl_p1 && o_busy == 5'h00 && !ctrl_q;
    endsequence
    sequence s_move14;
        o_busy[0] [*8] ##1 o_busy[0] [*6] ##1 !o_busy[0];
    endsequence
    AST_RD_ANSWER: assert property (i_req.rd |=> o_rd_valid)
        else $error("read not answered");
    AST_NO_STRAY_VALID: assert property (!i_req.rd |=> !o_rd_valid)
        else $error("stray read valid");
    AST_MASK_HI_RSVD: assert property (i_req.rd && i_req.offset == `ACLIA_OFF_MASK_HI
        |=> o_rdata[7:6] == 2'h0) else $error("mask high top bits set");
    AST_CTRL_RSVD: assert property (i_req.rd && i_req.offset == `ACLIA_OFF_CTRL
        |=> !o_rdata[7]) else $error("control bit 7 set");
    AST_FILTER_RSVD: assert property (i_req.rd && i_req.offset == `ACLIA_OFF_FILTER
        |=> o_rdata[7:1] == 7'h00) else $error("filter reserved bits set");
    AST_FILTER_P1: assert property (i_req.wr && i_req.sel == 8'h41
        && i_req.offset == `ACLIA_OFF_FILTER
        |=> o_redundancy_miss_force[0] == $past(i_req.wdata[0])) else $error("filter flag");
    AST_MOVE_LEN: assert property (s_start1 |-> ##2 s_move14)
        else $error("transfer span wrong");
    AST_BUSY_CAUSE: assert property ($rose(o_busy[0]) |-> $past(ctrl_p1, 2))
        else $error("busy without start");
    AST_DONE_LOW: assert property ((o_busy[0] && i_req.rd && i_req.sel == 8'h41
        && i_req.offset == `ACLIA_OFF_CTRL) ##1 o_busy[0] |-> o_rdata[6:5] != 2'b11)
        else $error("done flags high while moving");
endmodule : aclia_top_sva

bind aclia_top aclia_top_sva u_sva (
    .i_ref_clk               (i_ref_clk),
    .i_resetn                (i_resetn),
    .i_req                   (i_req),
    .o_rdata                 (o_rdata),
    .o_rd_valid              (o_rd_valid),
    .o_redundancy_miss_force (o_redundancy_miss_force),
    .o_busy                  (o_busy)
);
`default_nettype wire

// ### test/aclia_top_test.sv
// Purpose: self-checking bench of the rule-table access block
// Assumes: 20 MHz clock, one request per two cycles
// Notes:   all traffic on port 1 plus a filter sweep
`timescale 1ns/100ps
`default_nettype none
`include "aclia_regs.svh"

module aclia_top_test;
    logic                  i_ref_clk;
    logic                  i_resetn;
    aclia_pkg::aclia_req_t i_req;
    logic [7:0]            o_rdata;
    logic                  o_rd_valid;
    logic [4:0]            o_redundancy_miss_force;
    logic [4:0]            o_busy;
    int                    n_errors;
    int                    checked;
    logic [7:0]            got;
    logic [4:0]            exp_miss;

    aclia_top u_dut (
        .i_ref_clk               (i_ref_clk),
        .i_resetn                (i_resetn),
        .i_req                   (i_req),
        .o_rdata                 (o_rdata),
        .o_rd_valid              (o_rd_valid),
        .o_redundancy_miss_force (o_redundancy_miss_force),
        .o_busy                  (o_busy)
    );

    task automatic report_and_stop;
        $display("errors %0d, checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic acc(input logic w, input logic [7:0] sel, input logic [7:0] off,
                       input logic [7:0] d);
        @(posedge i_ref_clk);
        i_req <= {w, ~w, sel, off, d};
        @(posedge i_ref_clk);
        i_req <= '0;
        #1;
        got = o_rdata;
        if (!w) chk({7'h00, o_rd_valid}, 8'h01);
    endtask : acc

    task automatic rd(input logic [7:0] off, input logic [7:0] exp);
        acc(1'b0, 8'h41, off, 8'h00);
        chk(got, exp);
    endtask : rd

    task automatic poll(input int bitn);
        for (int k = 0; k < 40; k++) begin
            acc(1'b0, 8'h41, `ACLIA_OFF_CTRL, 8'h00);
            if (got[bitn] === 1'b1) return;
        end
        n_errors++;
        $display("CHECK FAILED at %0t: done flag stuck", $time);
        report_and_stop();
    endtask : poll

    task automatic s_reset_regs;
        rd(`ACLIA_OFF_MASK_HI, 8'h00);
        rd(`ACLIA_OFF_MASK_LO, 8'h00);
        rd(`ACLIA_OFF_CTRL, 8'h60);
        rd(`ACLIA_OFF_FILTER, 8'h00);
        acc(1'b1, 8'h41, `ACLIA_OFF_MASK_HI, 8'hff);
        rd(`ACLIA_OFF_MASK_HI, 8'h3f);
        acc(1'b1, 8'h41, `ACLIA_OFF_MASK_LO, 8'ha5);
        rd(`ACLIA_OFF_MASK_LO, 8'ha5);
        acc(1'b0, 8'h21, `ACLIA_OFF_MASK_LO, 8'h00);
        chk(got, 8'h00);
        rd(8'h0e, 8'h00);
    endtask : s_reset_regs

    task automatic s_filter;
        exp_miss = 5'h00;
        for (int p = 1; p <= 5; p++) begin
            acc(1'b1, 8'h40 | 8'(p), `ACLIA_OFF_FILTER, 8'hff);
            exp_miss[p-1] = 1'b1;
            chk({3'h0, o_redundancy_miss_force}, {3'h0, exp_miss});
        end
        rd(`ACLIA_OFF_FILTER, 8'h01);
        acc(1'b1, 8'h43, `ACLIA_OFF_FILTER, 8'h00);
        exp_miss[2] = 1'b0;
        chk({3'h0, o_redundancy_miss_force}, {3'h0, exp_miss});
    endtask : s_filter

    task automatic s_mid_reset;
        @(posedge i_ref_clk);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        #1;
        chk({3'h0, o_redundancy_miss_force}, 8'h00);
        rd(`ACLIA_OFF_FILTER, 8'h00);
        rd(`ACLIA_OFF_CTRL, 8'h60);
    endtask : s_mid_reset

    task automatic s_transfer;
        for (int i = 0; i < 14; i++) acc(1'b1, 8'h41, 8'(i), 8'h10 + 8'(i));
        acc(1'b1, 8'h41, `ACLIA_OFF_MASK_HI, 8'h15);
        acc(1'b1, 8'h41, `ACLIA_OFF_MASK_LO, 8'h55);
        acc(1'b1, 8'h41, `ACLIA_OFF_CTRL, 8'h1f);
        rd(`ACLIA_OFF_CTRL, 8'h3f);
        chk({3'h0, o_busy}, 8'h01);
        acc(1'b1, 8'h41, `ACLIA_OFF_CTRL, 8'h03);
        poll(`ACLIA_CTRL_WDONE);
        rd(`ACLIA_OFF_CTRL, 8'h7f);
        chk({3'h0, o_busy}, 8'h00);
        for (int i = 0; i < 14; i++) acc(1'b1, 8'h41, 8'(i), 8'h00);
        acc(1'b1, 8'h41, `ACLIA_OFF_MASK_HI, 8'h3f);
        acc(1'b1, 8'h41, `ACLIA_OFF_MASK_LO, 8'hff);
        acc(1'b1, 8'h41, `ACLIA_OFF_CTRL, 8'h0f);
        rd(`ACLIA_OFF_CTRL, 8'h4f);
        poll(`ACLIA_CTRL_RDONE);
        for (int i = 0; i < 14; i++) begin
            rd(8'(i), i[0] ? 8'h10 + 8'(i) : 8'h00);
        end
    endtask : s_transfer

    initial begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end

    initial begin
        n_errors = 0;
        checked  = 0;
        i_resetn = 1'b0;
        i_req    = '0;
        repeat (8) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        s_reset_regs();
        s_filter();
        s_mid_reset();
        s_transfer();
        report_and_stop();
    end
endmodule : aclia_top_test
`default_nettype wire
